// ---- design/tecc_pkg.sv ----
// Purpose: constants and helpers of the timer/event counter control
// Assumes: one channel, 16-bit register data port
// Notes:   8-bit control registers sit in the low data bits
package tecc_pkg;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [31:0] TECC_RUN_CLK_OFS  = 32'hfffff590;
    localparam logic [31:0] TECC_MODE_TRG_OFS = 32'h0ffff591;
    localparam logic [31:0] TECC_OUT_CTL_OFS  = 32'hfffff592;
    localparam logic [31:0] TECC_CAP_EDG_OFS  = 32'hfffff593;
    localparam logic [31:0] TECC_EVT_EDG_OFS  = 32'hfffff594;
    localparam logic [31:0] TECC_OPTION_OFS   = 32'hfffff595;
    localparam logic [31:0] TECC_COMPARE_BUFFER0_OFS     = 32'hfffff596;
    localparam logic [31:0] TECC_COMPARE_BUFFER1_OFS     = 32'hfffff598;
    localparam logic [31:0] TECC_CNT_OFS      = 32'hfffff59a;

    localparam logic [7:0]  TECC_CTRL_RST     = 8'h00;
    localparam logic [15:0] TECC_CCR_RST      = 16'h0000;
    localparam logic [15:0] TECC_CNT_STOP     = 16'hffff;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int TECC_RUN_BIT  = 7;
    localparam int TECC_SWT_BIT  = 6;
    localparam int TECC_EEE_BIT  = 5;
    localparam int TECC_OVF_BIT  = 0;
    localparam int TECC_CCS0_BIT = 4;
    localparam int TECC_CCS1_BIT = 5;

    // even channel divides by 64/128, odd by 256/512
    localparam logic TECC_ODD_CH = 1'b0;

    typedef enum logic [2:0] {
        TECC_MD_INTERVAL = 3'h0,
        TECC_MD_EVENT    = 3'h1,
        TECC_MD_TRIGGER  = 3'h2,
        TECC_MD_ONESHOT  = 3'h3,
        TECC_MD_PWM      = 3'h4,
        TECC_MD_FREERUN  = 3'h5,
        TECC_MD_PWMEAS   = 3'h6
    } tecc_mode_t;

    // valid edge from a 2-bit selection: none/rise/fall/both
    function automatic logic tecc_edge_hit(input logic [1:0] sel,
                                           input logic       rise,
                                           input logic       fall);
        tecc_edge_hit = (sel[0] & rise) | (sel[1] & fall);
    endfunction : tecc_edge_hit

endpackage : tecc_pkg

// ---- design/tecc_evt_if.sv ----
// Purpose: edge and tick signals between the channel modules
// Assumes: single clock domain
// Notes:   none
`timescale 1ns/1ns
`default_nettype none
interface tecc_evt_if;
    logic [1:0] rise;
    logic [1:0] fall;
    logic       tick;

    modport edge_src (output rise, output fall);
    modport tick_src (output tick);
    modport sink     (input rise, input fall, input tick);
endinterface : tecc_evt_if
`default_nettype wire

// ---- design/tecc_prescaler.sv ----
// Purpose: count-enable pulse at the selected internal division
// Assumes: run low clears the divider
// Notes:   tick is one cycle wide
`timescale 1ns/1ns
`default_nettype none
module tecc_prescaler
    import tecc_pkg::*;
(
    input  wire logic       clk_sys_i,
    input  wire logic       resetn_i,
    input  wire logic       ce_i,
    input  wire logic       run_i,
    input  wire logic [2:0] sel_i,
    tecc_evt_if.tick_src    evt
);
    logic [8:0] div_q;
    logic [8:0] mask;

    always_comb begin
        unique case (sel_i)
            3'h0: mask = 9'h000;
            3'h1: mask = 9'h001;
            3'h2: mask = 9'h003;
            3'h3: mask = 9'h007;
            3'h4: mask = 9'h00f;
            3'h5: mask = 9'h01f;
            3'h6: mask = TECC_ODD_CH ? 9'h0ff : 9'h03f;
            3'h7: mask = TECC_ODD_CH ? 9'h1ff : 9'h07f;
        endcase
    end

    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            div_q <= 9'h000;
        end else if (ce_i) begin
            div_q <= run_i ? div_q + 9'h001 : 9'h000;
        end
    end

    assign evt.tick = run_i && ((div_q & mask) == mask);
endmodule : tecc_prescaler
`default_nettype wire

// ---- design/tecc_edge_det.sv ----
// Purpose: synchronise both timer inputs and flag their edges
// Assumes: pins are asynchronous to the main clock
// Notes:   one pulse per edge
`timescale 1ns/1ns
`default_nettype none
module tecc_edge_det
    import tecc_pkg::*;
(
    input  wire logic       clk_sys_i,
    input  wire logic       resetn_i,
    input  wire logic       ce_i,
    input  wire logic [1:0] pin_i,
    tecc_evt_if.edge_src    evt
);
    logic [1:0] meta_q;
    logic [1:0] sync_q;
    logic [1:0] prev_q;

    for (genvar k = 0; k < 2; k++) begin : g_pin
        always_ff @(posedge clk_sys_i or negedge resetn_i) begin
            if (!resetn_i) begin
                meta_q[k] <= 1'b0;
                sync_q[k] <= 1'b0;
                prev_q[k] <= 1'b0;
            end else if (ce_i) begin
                meta_q[k] <= pin_i[k];
                sync_q[k] <= meta_q[k];
                prev_q[k] <= sync_q[k];
            end
        end
        assign evt.rise[k] = ce_i & sync_q[k] & ~prev_q[k];
        assign evt.fall[k] = ce_i & ~sync_q[k] & prev_q[k];
    end
endmodule : tecc_edge_det
`default_nettype wire

// ---- design/tecc_channel.sv ----
// Purpose: control part of one 16-bit timer/event counter channel
// Assumes: register port is synchronous, read data one cycle later
// Notes:   run low holds the channel in its stop state
//
// Overview of operation
// - each input edge select: none/rise/fall/both
// - counter clocked by prescaler or event edges
// - channel 0 match or capture interrupt
// - channel 1 match or capture interrupt
// - overflow interrupt after counting past all ones
// - run low resets flag, counter, outputs
// - run high starts counting; trigger and one-shot modes wait for a trigger
// - clock select picks division one to 128
// - same-value rewrite of run register harmless
// - software trigger acts as external trigger
// - software trigger ignored in other modes
// - event enable picks event or internal clock
// - event count mode always counts events
// - mode field selects seven timer modes
// - input pin 0 captures, counts, triggers
// - output control sets pin enable and level
// - stopped counter holds ones, reads zero
// - compare writes land in hidden buffer
`timescale 1ns/1ns
`default_nettype none
module tecc_channel
    import tecc_pkg::*;
(
    input  wire logic        clk_sys_i,
    input  wire logic        resetn_i,
    input  wire logic        ce_i,
    input  wire logic [31:0] addr_i,
    input  wire logic [15:0] wdata_i,
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    output logic      [15:0] rdata_o,
    input  wire logic        timer_input_pin0_i,
    input  wire logic        timer_input_pin1_i,
    output logic             timer_output_pin0_o,
    output logic             timer_output_pin1_o,
    output logic             match_capture_irq0_o,
    output logic             match_capture_irq1_o,
    output logic             overflow_irq_o
);
    typedef enum logic [2:0] {
        TECC_ST_IDLE  = 3'b001,
        TECC_ST_WAIT  = 3'b010,
        TECC_ST_COUNT = 3'b100
    } tecc_state_t;

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [7:0]  run_clock_control_reg_q;
    logic [7:0]  mode_trigger_control_reg_q;
    logic [7:0]  output_control_reg_q;
    logic [7:0]  capture_edge_reg_q;
    logic [7:0]  event_trigger_edge_reg_q;
    logic [5:4]  ccs_q;
    logic        overflow_flag_q;
    logic [15:0] ccr_q [2];
    logic [15:0] cmp_q [2];
    logic [15:0] cnt_q;
    logic [15:0] cnt_d;
    tecc_state_t state_q;
    tecc_state_t state_d;
    logic [1:0]  tout_raw_q;
    logic [1:0]  tout_raw_d;

    tecc_evt_if evt ();

    logic        run;
    logic [2:0]  mode;
    logic        wr_ctl0;
    logic        wr_ctl1;
    logic        sw_trig;
    logic        ext_sel;
    logic        ev_hit;
    logic        trg_hit;
    logic        cnt_en;
    logic        counting;
    logic        trg_mode;
    logic        clr_mode;
    logic        pulse_mode;
    logic        ovf_evt;
    logic [1:0]  cap_hit;
    logic [1:0]  cmp_hit;
    logic [1:0]  cc_evt;

    assign run  = run_clock_control_reg_q[TECC_RUN_BIT];
    assign mode = mode_trigger_control_reg_q[2:0];
    assign wr_ctl0 = ce_i && wr_i && (addr_i == TECC_RUN_CLK_OFS);
    assign wr_ctl1 = ce_i && wr_i && (addr_i == TECC_MODE_TRG_OFS);

    // ------------------------------------------------------------
    // sub-blocks
    // ------------------------------------------------------------
    tecc_prescaler u_pre (
        .clk_sys_i (clk_sys_i),
        .resetn_i  (resetn_i),
        .ce_i      (ce_i),
        .run_i     (run),
        .sel_i     (run_clock_control_reg_q[2:0]),
        .evt       (evt.tick_src)
    );

    tecc_edge_det u_edge (
        .clk_sys_i (clk_sys_i),
        .resetn_i  (resetn_i),
        .ce_i      (ce_i),
        .pin_i     ({timer_input_pin1_i, timer_input_pin0_i}),
        .evt       (evt.edge_src)
    );

    // ------------------------------------------------------------
    // mode decoding
    // ------------------------------------------------------------
    assign trg_mode = (mode == TECC_MD_TRIGGER) ||
                      (mode == TECC_MD_ONESHOT);
    assign clr_mode = (mode <= TECC_MD_PWM);
    assign pulse_mode = trg_mode || (mode == TECC_MD_PWM);
    assign counting = run && (state_q == TECC_ST_COUNT);
    assign ext_sel = (mode == TECC_MD_EVENT) ||
                     mode_trigger_control_reg_q[TECC_EEE_BIT];
    // pin 0 serves event count, trigger and capture
    assign ev_hit = tecc_edge_hit(event_trigger_edge_reg_q[3:2],
                                  evt.rise[0], evt.fall[0]);
    assign sw_trig = wr_ctl1 && wdata_i[TECC_SWT_BIT] && trg_mode;
    assign trg_hit = trg_mode && (sw_trig ||
                     tecc_edge_hit(event_trigger_edge_reg_q[1:0],
                                   evt.rise[0], evt.fall[0]));
    assign cnt_en = ce_i && (ext_sel ? ev_hit : evt.tick);

    for (genvar k = 0; k < 2; k++) begin : g_cc
        assign cap_hit[k] = counting &&
            ((mode == TECC_MD_PWMEAS) ||
             ((mode == TECC_MD_FREERUN) && ccs_q[TECC_CCS0_BIT + k])) &&
            tecc_edge_hit(capture_edge_reg_q[2*k +: 2],
                          evt.rise[k], evt.fall[k]);
        assign cmp_hit[k] = counting && cnt_en && !cap_hit[k] &&
            (mode != TECC_MD_PWMEAS) && (cnt_q == cmp_q[k]) &&
            !((mode == TECC_MD_FREERUN) && ccs_q[TECC_CCS0_BIT + k]);
        assign cc_evt[k] = cap_hit[k] || cmp_hit[k];
    end

    assign ovf_evt = counting && cnt_en && (cnt_q == TECC_CNT_STOP) &&
                     !(clr_mode && cmp_hit[0]);

    // ------------------------------------------------------------
    // control registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            run_clock_control_reg_q <= TECC_CTRL_RST;
        end else if (wr_ctl0) begin
            // reserved bits kept zero; same value changes nothing
            run_clock_control_reg_q <= {wdata_i[7], 4'h0,
                                        wdata_i[2:0]};
        end
    end

    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            mode_trigger_control_reg_q <= TECC_CTRL_RST;
        end else if (wr_ctl1) begin
            // trigger bit is a strobe and reads zero
            mode_trigger_control_reg_q <= {2'h0, wdata_i[5],
                                           2'h0, wdata_i[2:0]};
        end
    end

    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            output_control_reg_q     <= TECC_CTRL_RST;
            capture_edge_reg_q       <= TECC_CTRL_RST;
            event_trigger_edge_reg_q <= TECC_CTRL_RST;
            ccs_q                    <= 2'h0;
        end else if (ce_i && wr_i) begin
            unique case (addr_i)
                TECC_OUT_CTL_OFS:
                    output_control_reg_q <= {4'h0, wdata_i[3:0]};
                TECC_CAP_EDG_OFS:
                    capture_edge_reg_q <= {4'h0, wdata_i[3:0]};
                TECC_EVT_EDG_OFS:
                    event_trigger_edge_reg_q <= {4'h0, wdata_i[3:0]};
                TECC_OPTION_OFS:
                    ccs_q <= wdata_i[5:4];
                default: ;
            endcase
        end
    end

    // overflow flag: hardware set wins over a software clear
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            overflow_flag_q <= 1'b0;
        end else if (ce_i) begin
            if (!run) begin
                overflow_flag_q <= 1'b0;
            end else if (ovf_evt) begin
                overflow_flag_q <= 1'b1;
            end else if (wr_i && addr_i == TECC_OPTION_OFS) begin
                overflow_flag_q <= wdata_i[TECC_OVF_BIT];
            end
        end
    end

    // capture/compare registers and hidden compare buffers
    for (genvar k = 0; k < 2; k++) begin : g_ccr
        always_ff @(posedge clk_sys_i or negedge resetn_i) begin
            if (!resetn_i) begin
                ccr_q[k] <= TECC_CCR_RST;
                cmp_q[k] <= TECC_CCR_RST;
            end else if (ce_i) begin
                if (cap_hit[k]) begin
                    ccr_q[k] <= cnt_q;
                end else if (wr_i && addr_i ==
                             (k == 0 ? TECC_COMPARE_BUFFER0_OFS : TECC_COMPARE_BUFFER1_OFS)) begin
                    ccr_q[k] <= wdata_i;
                    cmp_q[k] <= wdata_i;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // sequencing and counter
    // ------------------------------------------------------------
    always_comb begin
        state_d    = state_q;
        cnt_d      = cnt_q;
        tout_raw_d = tout_raw_q;
        unique case (state_q)
            TECC_ST_IDLE: begin
                if (run) begin
                    state_d = trg_mode ? TECC_ST_WAIT : TECC_ST_COUNT;
                    cnt_d   = trg_mode ? TECC_CNT_STOP : 16'h0000;
                    tout_raw_d[1] = pulse_mode && !trg_mode;
                end
            end
            TECC_ST_WAIT: begin
                if (trg_hit) begin
                    state_d = TECC_ST_COUNT;
                    cnt_d   = 16'h0000;
                    tout_raw_d[1] = 1'b1;
                end
            end
            TECC_ST_COUNT: begin
                if (mode == TECC_MD_TRIGGER && trg_hit) begin
                    cnt_d = 16'h0000;
                    tout_raw_d[1] = 1'b1;
                end else if (cap_hit[0] && mode == TECC_MD_PWMEAS) begin
                    cnt_d = 16'h0000;
                end else if (cmp_hit[0] && clr_mode) begin
                    if (mode == TECC_MD_ONESHOT) begin
                        state_d = TECC_ST_WAIT;
                        cnt_d   = TECC_CNT_STOP;
                    end else begin
                        cnt_d = 16'h0000;
                    end
                    tout_raw_d[1] = pulse_mode && !trg_mode;
                end else if (cnt_en) begin
                    cnt_d = cnt_q + 16'h0001;
                end
                if (cmp_hit[0] && !pulse_mode) begin
                    tout_raw_d[0] = ~tout_raw_q[0];
                end
                if (cmp_hit[1]) begin
                    tout_raw_d[1] = pulse_mode ? 1'b0 : ~tout_raw_q[1];
                end
            end
            default: begin
                state_d = TECC_ST_IDLE;
            end
        endcase
        if (!run) begin
            state_d    = TECC_ST_IDLE;
            cnt_d      = TECC_CNT_STOP;
            tout_raw_d = 2'h0;
        end
    end

    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state_q    <= TECC_ST_IDLE;
            cnt_q      <= TECC_CNT_STOP;
            tout_raw_q <= 2'h0;
        end else if (ce_i) begin
            state_q    <= state_d;
            cnt_q      <= cnt_d;
            tout_raw_q <= tout_raw_d;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            timer_output_pin0_o <= 1'b0;
            timer_output_pin1_o <= 1'b0;
        end else if (ce_i) begin
            // disabled pin shows its level bit
            timer_output_pin0_o <= output_control_reg_q[0] ?
                tout_raw_d[0] ^ output_control_reg_q[1] :
                output_control_reg_q[1];
            timer_output_pin1_o <= output_control_reg_q[2] ?
                tout_raw_d[1] ^ output_control_reg_q[3] :
                output_control_reg_q[3];
        end
    end

    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            match_capture_irq0_o <= 1'b0;
            match_capture_irq1_o <= 1'b0;
            overflow_irq_o       <= 1'b0;
        end else begin
            match_capture_irq0_o <= ce_i && cc_evt[0];
            match_capture_irq1_o <= ce_i && cc_evt[1];
            overflow_irq_o       <= ce_i && ovf_evt;
        end
    end

    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rdata_o <= 16'h0000;
        end else if (ce_i) begin
            rdata_o <= 16'h0000;
            if (rd_i) begin
                unique case (addr_i)
                    TECC_RUN_CLK_OFS:  rdata_o <= {8'h00,
                        run_clock_control_reg_q};
                    TECC_MODE_TRG_OFS: rdata_o <= {8'h00,
                        mode_trigger_control_reg_q};
                    TECC_OUT_CTL_OFS:  rdata_o <= {8'h00,
                        output_control_reg_q};
                    TECC_CAP_EDG_OFS:  rdata_o <= {8'h00,
                        capture_edge_reg_q};
                    TECC_EVT_EDG_OFS:  rdata_o <= {8'h00,
                        event_trigger_edge_reg_q};
                    TECC_OPTION_OFS:   rdata_o <= {10'h000, ccs_q,
                        3'h0, overflow_flag_q};
                    TECC_COMPARE_BUFFER0_OFS:     rdata_o <= ccr_q[0];
                    TECC_COMPARE_BUFFER1_OFS:     rdata_o <= ccr_q[1];
                    TECC_CNT_OFS:      rdata_o <= run ? cnt_q :
                                                  16'h0000;
                    default:           rdata_o <= 16'h0000;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!resetn_i);

    sequence s_wait_trig;
        ce_i && state_q == TECC_ST_WAIT && trg_hit && run;
    endsequence

    sequence s_started;
        state_q == TECC_ST_COUNT && cnt_q == 16'h0000;
    endsequence

    AST_STOP_HOLD: assert property (
        ce_i && !run |=> cnt_q == TECC_CNT_STOP && !overflow_flag_q &&
                         state_q == TECC_ST_IDLE)
        else $error("stopped counter not held at ones");

    AST_READ_ZERO: assert property (
        ce_i && rd_i && addr_i == TECC_CNT_OFS && !run
        |=> rdata_o == 16'h0000)
        else $error("stopped counter read not zero");

    AST_OVF: assert property (
        ce_i && ovf_evt |=> overflow_irq_o && cnt_q == 16'h0000 &&
                            overflow_flag_q)
        else $error("overflow not signalled");

    AST_CC0: assert property (
        ce_i && cmp_hit[0] |=> match_capture_irq0_o)
        else $error("channel 0 match lost");

    AST_CC1: assert property (
        ce_i && cap_hit[1] |=> match_capture_irq1_o &&
                               ccr_q[1] == $past(cnt_q))
        else $error("channel 1 capture lost");

    AST_SWT_IGN: assert property (
        wr_ctl1 && wdata_i[TECC_SWT_BIT] && mode == TECC_MD_INTERVAL &&
        wdata_i[2:0] == 3'h0 && counting && cnt_en && !cmp_hit[0]
        |=> cnt_q == $past(cnt_q) + 16'h0001)
        else $error("software trigger not ignored");

    AST_TRIG: assert property (
        s_wait_trig |=> s_started)
        else $error("trigger did not start counting");

    AST_START: assert property (
        ce_i && state_q == TECC_ST_IDLE && run && !trg_mode
        |=> s_started)
        else $error("run did not start counter");

    AST_EVT_SRC: assert property (
        ce_i && counting && mode == TECC_MD_EVENT && !ev_hit &&
        run && !cmp_hit[0] |=> $stable(cnt_q))
        else $error("event mode counted without edge");

    AST_SET_WINS: assert property (
        ce_i && run && ovf_evt && wr_i && addr_i == TECC_OPTION_OFS
        |=> overflow_flag_q)
        else $error("overflow set lost to clear");

endmodule : tecc_channel
`default_nettype wire

// ---- tb/tecc_pin_model.sv ----
// Purpose: far-side model driving the timer input pins
// Assumes: pins idle low between pulses
// Notes:   each level is held four main clocks
`timescale 1ns/1ns
`default_nettype none
module tecc_pin_model (
    input  wire logic clk_sys_i,
    output logic      pin0_o,
    output logic      pin1_o
);
    initial begin
        pin0_o = 1'b0;
        pin1_o = 1'b0;
    end
    // n full pulses on pin 0
    task automatic pulse(input int n);
        repeat (n) begin
            repeat (4) @(posedge clk_sys_i);
            pin0_o <= 1'b1;
            repeat (4) @(posedge clk_sys_i);
            pin0_o <= 1'b0;
        end
    endtask : pulse
    // n full pulses on pin 1
    task automatic pulse1(input int n);
        repeat (n) begin
            repeat (4) @(posedge clk_sys_i);
            pin1_o <= 1'b1;
            repeat (4) @(posedge clk_sys_i);
            pin1_o <= 1'b0;
        end
    endtask : pulse1
endmodule : tecc_pin_model
`default_nettype wire

// ---- tb/tecc_channel_tb_top.sv ----
// Purpose: self-checking bench of the timer channel control
// Assumes: even channel, register port one cycle read latency
// Notes:   overflow scenario runs a full 16-bit count
`timescale 1ns/1ns
`default_nettype none
module tecc_channel_tb_top;
    import tecc_pkg::*;
    logic        clk_sys_i = 1'b0;
    logic        resetn_i  = 1'b0;
    logic        ce_i      = 1'b1;
    logic [31:0] addr      = 32'h0;
    logic [15:0] wdata     = 16'h0;
    logic        wr        = 1'b0;
    logic        rd        = 1'b0;
    logic [15:0] rdata;
    logic        pin0, pin1, out0, out1, irq0, irq1, ovf;
    int          n_errors    = 0;
    int          comparisons = 0;
    always #10 clk_sys_i = ~clk_sys_i;
    tecc_channel tecc_channel_i (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i),
        .ce_i(ce_i), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
        .rdata_o(rdata), .timer_input_pin0_i(pin0),
        .timer_input_pin1_i(pin1), .timer_output_pin0_o(out0),
        .timer_output_pin1_o(out1), .match_capture_irq0_o(irq0),
        .match_capture_irq1_o(irq1), .overflow_irq_o(ovf));
    tecc_pin_model tecc_pin_model_i (.clk_sys_i(clk_sys_i), .pin0_o(pin0),
        .pin1_o(pin1));
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic wr_reg(input logic [31:0] a, input logic [15:0] d);
        @(posedge clk_sys_i);
        wr <= 1'b1; addr <= a; wdata <= d;
        @(posedge clk_sys_i);
        wr <= 1'b0;
    endtask : wr_reg
    task automatic rd_chk(input logic [31:0] a, input logic [15:0] e);
        @(posedge clk_sys_i);
        rd <= 1'b1; addr <= a;
        @(posedge clk_sys_i);
        rd <= 1'b0;
        #1 check(rdata, e);
    endtask : rd_chk
    // wait for irq0 (sel 0), overflow (sel 1) or irq1 (sel 2)
    task automatic wait_hit(input int sel, input int lim);
        logic hit;
        hit = 1'b0;
        for (int i = 0; i < lim && !hit; i++) begin
            @(posedge clk_sys_i);
            #1 hit = (sel == 0) ? (irq0 === 1'b1) :
                     (sel == 2) ? (irq1 === 1'b1) : (ovf === 1'b1);
        end
        check({15'h0, hit}, 16'h0001);
    endtask : wait_hit
    task automatic t_regs();
        rd_chk(TECC_RUN_CLK_OFS, 16'h0000);
        rd_chk(TECC_MODE_TRG_OFS, 16'h0000);
        rd_chk(32'hfffff5ff, 16'h0000);
        wr_reg(TECC_RUN_CLK_OFS, 16'h0087);
        rd_chk(TECC_RUN_CLK_OFS, 16'h0087);
        wr_reg(TECC_RUN_CLK_OFS, 16'h0087);
        rd_chk(TECC_RUN_CLK_OFS, 16'h0087);
        wr_reg(TECC_RUN_CLK_OFS, 16'h0000);
        rd_chk(TECC_CNT_OFS, 16'h0000);
        check({14'h0, out1, out0}, 16'h0000);
    endtask : t_regs
    task automatic t_interval();
        wr_reg(TECC_OUT_CTL_OFS, 16'h0001);
        wr_reg(TECC_COMPARE_BUFFER0_OFS, 16'h0003);
        wr_reg(TECC_MODE_TRG_OFS, 16'h0000);
        wr_reg(TECC_RUN_CLK_OFS, 16'h0080);
        wait_hit(0, 20);
        check({15'h0, out0}, 16'h0001);
        wr_reg(TECC_MODE_TRG_OFS, 16'h0040);
        rd_chk(TECC_MODE_TRG_OFS, 16'h0000);
        wait_hit(0, 20);
        wr_reg(TECC_RUN_CLK_OFS, 16'h0000);
        @(posedge clk_sys_i);
        #1 check({15'h0, out0}, 16'h0000);
    endtask : t_interval
    task automatic t_event();
        wr_reg(TECC_EVT_EDG_OFS, 16'h0004);
        wr_reg(TECC_COMPARE_BUFFER0_OFS, 16'h0010);
        wr_reg(TECC_MODE_TRG_OFS, 16'h0001);
        wr_reg(TECC_RUN_CLK_OFS, 16'h0080);
        tecc_pin_model_i.pulse(3);
        // pulse while frozen must not count
        ce_i <= 1'b0;
        tecc_pin_model_i.pulse(1);
        ce_i <= 1'b1;
        repeat (6) @(posedge clk_sys_i);
        rd_chk(TECC_CNT_OFS, 16'h0003);
        wr_reg(TECC_RUN_CLK_OFS, 16'h0000);
    endtask : t_event
    task automatic t_oneshot();
        wr_reg(TECC_COMPARE_BUFFER0_OFS, 16'h0005);
        wr_reg(TECC_MODE_TRG_OFS, 16'h0003);
        wr_reg(TECC_RUN_CLK_OFS, 16'h0080);
        rd_chk(TECC_CNT_OFS, 16'hffff);
        wr_reg(TECC_MODE_TRG_OFS, 16'h0043);
        wait_hit(0, 20);
        rd_chk(TECC_CNT_OFS, 16'hffff);
        wr_reg(TECC_RUN_CLK_OFS, 16'h0000);
    endtask : t_oneshot
    task automatic t_ovf();
        wr_reg(TECC_CAP_EDG_OFS, 16'h0004);
        wr_reg(TECC_OPTION_OFS, 16'h0020);
        wr_reg(TECC_MODE_TRG_OFS, 16'h0005);
        wr_reg(TECC_RUN_CLK_OFS, 16'h0080);
        fork
            tecc_pin_model_i.pulse1(1);
            wait_hit(2, 20);
        join
        wait_hit(1, 70000);
        rd_chk(TECC_OPTION_OFS, 16'h0021);
        wr_reg(TECC_RUN_CLK_OFS, 16'h0000);
        rd_chk(TECC_OPTION_OFS, 16'h0020);
    endtask : t_ovf
    task automatic results();
        $display("errors=%0d comparisons=%0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : results
    initial begin
        repeat (10) @(posedge clk_sys_i);
        resetn_i <= 1'b1;
        t_regs();
        t_interval();
        t_event();
        t_oneshot();
        t_ovf();
        results();
    end
    initial begin
        #2000000;
        n_errors++;
        results();
    end
endmodule : tecc_channel_tb_top
`default_nettype wire
